// File: hw/wct_pkg.sv
// Constants and types shared by the waveform counter timing block
package wct_pkg;

   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_STRB = 8'h08;
   localparam logic [7:0] A_BLEN = 8'h0C;
   localparam logic [7:0] A_DIVIDED_FREQUENCY_PIN = 8'h10;
   localparam logic [7:0] A_CFG = 8'h20;
   localparam logic [7:0] A_LOAD = 8'h40;
   localparam logic [7:0] A_CNT = 8'h60;

   // ==========================================================
   // Control register fields
   localparam int C_WAVE = 0;
   localparam int C_TRIG = 1;
   localparam int C_CYC = 2;
   localparam int C_STOP = 3;
   localparam int C_MODE = 4;
   localparam int C_USEL = 6;
   localparam int C_REQ = 9;
   localparam int CTRL_W = 10;
   localparam logic [1:0] MODE_CONT = 2'h0;
   localparam logic [1:0] MODE_PROG = 2'h1;
   localparam logic [1:0] MODE_PULSE = 2'h2;
   localparam logic [2:0] U_C1 = 3'h0;
   localparam logic [2:0] U_C2 = 3'h1;
   localparam logic [2:0] U_C3 = 3'h2;
   localparam logic [2:0] U_C5 = 3'h3;
   localparam logic [2:0] U_EXT = 3'h4;

   // ==========================================================
   // Counter configuration fields
   localparam int F_SRC = 0;
   localparam int F_FALL = 5;
   localparam int F_GATE = 6;
   localparam int F_TGL = 9;
   localparam int F_INV = 10;
   localparam int F_OST = 11;
   localparam int F_CAS = 13;
   localparam int CFG_W = 14;
   localparam logic [4:0] SRC_PREV = 5'h10;
   localparam logic [4:0] SRC_DIVIDED_FREQUENCY_PIN_LAST = 5'h0F;
   localparam logic [2:0] G_NONE = 3'h0;
   localparam logic [2:0] G_HIGH = 3'h1;
   localparam logic [2:0] G_LOW = 3'h2;
   localparam logic [2:0] G_RISE = 3'h3;
   localparam logic [2:0] G_FALL = 3'h4;
   localparam logic [2:0] G_UP = 3'h5;
   localparam logic [2:0] G_DOWN = 3'h6;
   localparam logic [1:0] O_HIZ = 2'h1;
   localparam logic [1:0] O_LOW = 2'h2;

   // ==========================================================
   // Strobe bits, timebase and reset values
   localparam int S_START = 0;
   localparam int S_CLR = 1;
   localparam int S_UPD = 2;
   localparam int S_CDONE = 3;
   localparam int S_CREQ = 4;
   localparam int NCNT = 5;
   localparam logic [2:0] TB_LAST = 3'h4;
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RUN = 4'h2,
      ST_GAP = 4'h4,
      ST_DONE = 4'h8
   } wct_state_e;

endpackage : wct_pkg

// File: hw/wct_timing.sv
// Counter/timer and cyclic waveform sequencing block with APB registers
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module wct_timing #(
   parameter int CW = 16,
   parameter int BUF_DEPTH = 2048
)
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic BOARD_TIMEBASE_CLOCK,
   input wire logic [4:0] SOURCE_IN,
   input wire logic [3:0] GATE_PINS,
   input wire logic EXTERNAL_TRIGGER_PIN_N,
   input wire logic EXT_UPDATE_TRIG_N,
   input wire logic OVERFLOW,
   input wire logic OVERRUN,
   output logic [4:0] COUNTER_OUT,
   output logic [4:0] COUNTER_OUT_OE_N,
   output logic COUNTER_CLOCK,
   output logic DIVIDED_FREQUENCY_PIN,
   output logic COUNTER_FOUR_GATE,
   output logic DAC_UPDATE_N,
   output logic FIFO_REPLAY_PULSE_N,
   output logic REQUEST
);

   localparam int IW = $clog2(BUF_DEPTH) + 1;

   typedef struct packed {
      logic rdy;
      logic err;
      logic [31:0] rdata;
      logic [wct_pkg::CTRL_W-1:0] ctrl;
      logic [IW-1:0] blen;
      logic [8:0] foc;
      logic [4:0][wct_pkg::CFG_W-1:0] cfg;
      logic [4:0][CW-1:0] ld;
      logic [4:0][CW-1:0] cnt;
      logic [4:0] sprev;
      logic [4:0] gprev;
      logic [4:0] arm;
      logic [4:0] tcp;
      logic [4:0] tgl;
      logic [4:0] pin;
      logic [4:0] oe_n;
      logic bprev;
      logic [5:0] tb;
      logic [5:1][2:0] pc;
      logic fprev;
      logic [3:0] fcnt;
      logic fo;
      logic g4;
      logic tprev;
      logic uprev;
      logic upd_n;
      logic rpl_n;
      logic req;
      logic done;
      logic [IW-1:0] idx;
      wct_pkg::wct_state_e st;
   } wct_state_s;

   wct_state_s s_r;
   wct_state_s s_nxt;

   always_comb
   begin
      wct_state_s n;
      logic rd_ph;
      logic wr;
      logic kv;
      logic h_ctrl, h_stat, h_strb, h_blen, h_divided_frequency_pin, h_cfg, h_ld, h_cnt;
      logic [2:0] ki;
      logic [4:0] stb;
      logic tick;
      logic [4:0] gv;
      logic [4:0] raw;
      logic [4:0] tc;
      logic [16:0] sv;
      logic [4:0] sel;
      logic sl, ev, run, g, ul, ufall, upd, replay, cyc, fl;
      logic [1:0] mode;
      logic [4:0] dd;
      n = s_r;
      rd_ph = PSEL & PENABLE & ~s_r.rdy;
      wr = PSEL & PENABLE & s_r.rdy & PWRITE;
      ki = PADDR[4:2];
      kv = (ki < 3'h5) && (PADDR[1:0] == 2'h0);
      tc = '0;
      sv = '0;
      sel = '0;
      sl = 1'b0;
      ev = 1'b0;
      run = 1'b0;
      g = 1'b0;
      fl = 1'b0;
      // ==========================================================
      // APB decode, read data one wait state after setup
      h_ctrl = PADDR == wct_pkg::A_CTRL;
      h_stat = PADDR == wct_pkg::A_STAT;
      h_strb = PADDR == wct_pkg::A_STRB;
      h_blen = PADDR == wct_pkg::A_BLEN;
      h_divided_frequency_pin = PADDR == wct_pkg::A_DIVIDED_FREQUENCY_PIN;
      h_cfg = (PADDR[7:5] == wct_pkg::A_CFG[7:5]) && kv;
      h_ld = (PADDR[7:5] == wct_pkg::A_LOAD[7:5]) && kv;
      h_cnt = (PADDR[7:5] == wct_pkg::A_CNT[7:5]) && kv;
      n.rdy = rd_ph;
      n.err = 1'b0;
      n.rdata = '0;
      if (rd_ph)
      begin
         if (h_ctrl)
            n.rdata = 32'(s_r.ctrl);
         else if (h_stat)
            n.rdata = 32'({s_r.pin, s_r.st, s_r.req, s_r.g4, s_r.done});
         else if (h_strb)
            n.rdata = '0;
         else if (h_blen)
            n.rdata = 32'(s_r.blen);
         else if (h_divided_frequency_pin)
            n.rdata = 32'(s_r.foc);
         else if (h_cfg)
            n.rdata = 32'(s_r.cfg[ki]);
         else if (h_ld)
            n.rdata = 32'(s_r.ld[ki]);
         else if (h_cnt)
            n.rdata = 32'(s_r.cnt[ki]);
         else
            n.err = 1'b1;
      end
      stb = (wr && h_strb) ? PWDATA[4:0] : 5'h00;
      if (wr && h_ctrl)
         n.ctrl = PWDATA[wct_pkg::CTRL_W-1:0];
      if (wr && h_blen)
         n.blen = PWDATA[IW-1:0];
      if (wr && h_divided_frequency_pin)
         n.foc = PWDATA[8:0];
      if (wr && h_cfg)
         n.cfg[ki] = PWDATA[wct_pkg::CFG_W-1:0];
      if (wr && h_ld)
      begin
         n.ld[ki] = PWDATA[CW-1:0];
         n.cnt[ki] = PWDATA[CW-1:0];
      end
      cyc = s_r.ctrl[wct_pkg::C_CYC];
      mode = s_r.ctrl[wct_pkg::C_MODE +: 2];
      // ==========================================================
      // Timebases: board clock halved, and a decade chain counted from the board clock itself
      tick = BOARD_TIMEBASE_CLOCK & ~s_r.bprev;
      n.bprev = BOARD_TIMEBASE_CLOCK;
      if (tick)
         n.tb[0] = ~s_r.tb[0];
      for (int k = 1; k < 6; k++)
      begin
         if (tick)
         begin
            if (s_r.pc[k] == wct_pkg::TB_LAST)
            begin
               n.pc[k] = 3'h0;
               n.tb[k] = ~s_r.tb[k];
               tick = ~s_r.tb[k];
            end
            else
            begin
               n.pc[k] = s_r.pc[k] + 3'h1;
               tick = 1'b0;
            end
         end
      end
      // ==========================================================
      // Update trigger, replay and request
      case (s_r.ctrl[wct_pkg::C_USEL +: 3])
         wct_pkg::U_C1: ul = s_r.pin[0];
         wct_pkg::U_C2: ul = s_r.pin[1];
         wct_pkg::U_C3: ul = s_r.pin[2];
         wct_pkg::U_C5: ul = s_r.pin[4];
         wct_pkg::U_EXT: ul = EXT_UPDATE_TRIG_N;
         default: ul = ~stb[wct_pkg::S_UPD];
      endcase
      n.uprev = ul;
      ufall = s_r.uprev & ~ul;
      if (stb[wct_pkg::S_CREQ])
         n.req = 1'b0;
      if (s_r.ctrl[wct_pkg::C_REQ] && ufall)
         n.req = 1'b1;
      upd = ufall && s_r.ctrl[wct_pkg::C_WAVE] && s_r.ctrl[wct_pkg::C_TRIG]
         && (s_r.st == wct_pkg::ST_RUN);
      n.upd_n = ~upd;
      replay = upd && cyc && (s_r.idx == s_r.blen - IW'(1));
      if (upd && cyc)
         n.idx = replay ? '0 : s_r.idx + IW'(1);
      n.rpl_n = ~replay;
      // ==========================================================
      // Counters
      gv = {GATE_PINS[3], s_r.g4, GATE_PINS[2:0]};
      for (int i = 0; i < 5; i++)
         raw[i] = s_r.cfg[i][wct_pkg::F_TGL] ? s_r.tgl[i] : s_r.tcp[i];
      for (int i = 0; i < 5; i++)
      begin
         sv = {raw[(i + 4) % 5], SOURCE_IN, gv, s_r.tb};
         sel = s_r.cfg[i][wct_pkg::F_SRC +: 5];
         sl = (sel <= wct_pkg::SRC_PREV) ? sv[sel] : 1'b0;
         n.sprev[i] = sl;
         ev = s_r.cfg[i][wct_pkg::F_FALL] ? (s_r.sprev[i] & ~sl)
            : (~s_r.sprev[i] & sl);
         if (i == 0 && cyc && mode != wct_pkg::MODE_CONT)
            ev = replay;
         if (i > 0 && s_r.cfg[i][wct_pkg::F_CAS])
            ev = tc[(i + 4) % 5];
         g = gv[i];
         n.gprev[i] = g;
         case (s_r.cfg[i][wct_pkg::F_GATE +: 3])
            wct_pkg::G_NONE: run = 1'b1;
            wct_pkg::G_HIGH: run = g;
            wct_pkg::G_LOW: run = ~g;
            wct_pkg::G_RISE:
            begin
               if (~s_r.gprev[i] & g)
                  n.arm[i] = 1'b1;
               run = n.arm[i];
            end
            wct_pkg::G_FALL:
            begin
               if (s_r.gprev[i] & ~g)
                  n.arm[i] = 1'b1;
               run = n.arm[i];
            end
            wct_pkg::G_UP: run = gv[(i + 1) % 5];
            wct_pkg::G_DOWN: run = gv[(i + 4) % 5];
            default: run = 1'b0;
         endcase
         if (i == 1 && cyc && mode == wct_pkg::MODE_PULSE)
            run = run && (s_r.st == wct_pkg::ST_GAP);
         if (ev && run)
         begin
            n.tcp[i] = 1'b0;
            if (n.cnt[i] <= CW'(1))
            begin
               n.cnt[i] = n.ld[i];
               tc[i] = 1'b1;
               n.tcp[i] = 1'b1;
               n.tgl[i] = ~s_r.tgl[i];
               n.arm[i] = 1'b0;
            end
            else
               n.cnt[i] = n.cnt[i] - CW'(1);
         end
         raw[i] = s_r.cfg[i][wct_pkg::F_TGL] ? n.tgl[i] : n.tcp[i];
         if (s_r.cfg[i][wct_pkg::F_OST +: 2] == wct_pkg::O_LOW)
            n.pin[i] = 1'b0;
         else
            n.pin[i] = raw[i] ^ s_r.cfg[i][wct_pkg::F_INV];
         n.oe_n[i] = s_r.cfg[i][wct_pkg::F_OST +: 2] == wct_pkg::O_HIZ;
      end
      // ==========================================================
      // Counter 4 gate flop
      n.tprev = EXTERNAL_TRIGGER_PIN_N;
      if ((s_r.tprev & ~EXTERNAL_TRIGGER_PIN_N) | stb[wct_pkg::S_START])
         n.g4 = 1'b1;
      if ((s_r.cfg[4][wct_pkg::F_CAS] ? tc[4] : tc[3]) | OVERFLOW | OVERRUN
         | stb[wct_pkg::S_CLR])
         n.g4 = 1'b0;
      // ==========================================================
      // Waveform sequencer
      if (stb[wct_pkg::S_CDONE])
         n.done = 1'b0;
      case (s_r.st)
         wct_pkg::ST_IDLE:
         begin
            n.idx = '0;
            n.st = wct_pkg::ST_RUN;
         end
         wct_pkg::ST_RUN:
         begin
            if (replay && s_r.ctrl[wct_pkg::C_STOP])
               n.st = wct_pkg::ST_DONE;
            else if (replay && tc[0] && mode == wct_pkg::MODE_PROG)
            begin
               n.st = wct_pkg::ST_DONE;
               n.done = 1'b1;
            end
            else if (replay && tc[0] && mode == wct_pkg::MODE_PULSE)
               n.st = wct_pkg::ST_GAP;
         end
         wct_pkg::ST_GAP:
         begin
            if (s_r.ctrl[wct_pkg::C_STOP])
               n.st = wct_pkg::ST_DONE;
            else if (tc[1])
               n.st = wct_pkg::ST_RUN;
         end
         wct_pkg::ST_DONE: n.st = wct_pkg::ST_DONE;
         default: n.st = wct_pkg::ST_IDLE;
      endcase
      if (!(s_r.ctrl[wct_pkg::C_TRIG] && s_r.ctrl[wct_pkg::C_WAVE]))
         n.st = wct_pkg::ST_IDLE;
      // ==========================================================
      // Frequency output divider
      sel = s_r.foc[4:0];
      sv = {1'b0, SOURCE_IN, gv, s_r.tb};
      fl = (sel <= wct_pkg::SRC_DIVIDED_FREQUENCY_PIN_LAST) ? sv[sel] : 1'b0;
      n.fprev = fl;
      dd = (s_r.foc[8:5] == 4'h0) ? 5'h10 : {1'b0, s_r.foc[8:5]};
      if (~s_r.fprev & fl)
         n.fcnt = ({1'b0, s_r.fcnt} + 5'h01 >= dd) ? 4'h0 : s_r.fcnt + 4'h1;
      n.fo = (dd == 5'h01) ? fl : ({1'b0, n.fcnt} < (dd >> 1));
      s_nxt = n;
   end

   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         s_r <= '0;
         s_r.ctrl <= wct_pkg::CTRL_RST;
         s_r.uprev <= 1'b1;
         s_r.tprev <= 1'b1;
         s_r.upd_n <= 1'b1;
         s_r.rpl_n <= 1'b1;
         s_r.st <= wct_pkg::ST_IDLE;
      end
      else
         s_r <= s_nxt;
   end

   assign PRDATA = s_r.rdata;
   assign PREADY = s_r.rdy;
   assign PSLVERR = s_r.err;
   assign COUNTER_OUT = s_r.pin;
   assign COUNTER_OUT_OE_N = s_r.oe_n;
   assign COUNTER_CLOCK = s_r.tb[1];
   assign DIVIDED_FREQUENCY_PIN = s_r.fo;
   assign COUNTER_FOUR_GATE = s_r.g4;
   assign DAC_UPDATE_N = s_r.upd_n;
   assign FIFO_REPLAY_PULSE_N = s_r.rpl_n;
   assign REQUEST = s_r.req;

endmodule : wct_timing

`default_nettype wire

// File: tb/wct_checker.sv
// Port-level assertions for the timing block
`timescale 1ns/100ps
`default_nettype none
module wct_checker (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic EXTERNAL_TRIGGER_PIN_N,
   input wire logic OVERFLOW,
   input wire logic OVERRUN,
   input wire logic COUNTER_FOUR_GATE,
   input wire logic DAC_UPDATE_N,
   input wire logic FIFO_REPLAY_PULSE_N,
   input wire logic REQUEST
);
   logic trig_d_r;
   wire logic strb_wr;
   wire logic set_cause;
   wire logic req_clr;
   assign strb_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == wct_pkg::A_STRB;
   assign set_cause = (trig_d_r && !EXTERNAL_TRIGGER_PIN_N)
      || (strb_wr && PWDATA[wct_pkg::S_START]);
   assign req_clr = strb_wr && PWDATA[wct_pkg::S_CREQ];
   always_ff @(posedge CLK)
   begin
      trig_d_r <= EXTERNAL_TRIGGER_PIN_N;
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   // ========
   // Multi-step shapes
   sequence s_wait_ready;
      !PREADY ##1 PREADY;
   endsequence
   sequence s_upd_low;
      !DAC_UPDATE_N ##1 DAC_UPDATE_N;
   endsequence
   a_apb_wait: assert property (PSEL && !PENABLE |=> s_wait_ready)
      else $error("ready timing wrong");
   a_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   a_upd_pulse: assert property ($fell(DAC_UPDATE_N) |-> s_upd_low)
      else $error("update pulse width wrong");
   a_replay_upd: assert property (!FIFO_REPLAY_PULSE_N |-> !DAC_UPDATE_N)
      else $error("replay without update");
   a_replay_once: assert property ($fell(FIFO_REPLAY_PULSE_N) |=> FIFO_REPLAY_PULSE_N)
      else $error("replay pulse too long");
   a_gate_clr: assert property (OVERFLOW || OVERRUN |=> !COUNTER_FOUR_GATE)
      else $error("gate not cleared");
   a_gate_cause: assert property ($rose(COUNTER_FOUR_GATE) |->
      $past(set_cause) || $past(set_cause, 2) || $past(set_cause, 3))
      else $error("gate set without cause");
   a_req_hold: assert property (REQUEST && !req_clr && !$past(req_clr) |=> REQUEST)
      else $error("request dropped");
endmodule : wct_checker
bind wct_timing wct_checker u_chk (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .EXTERNAL_TRIGGER_PIN_N(EXTERNAL_TRIGGER_PIN_N), .OVERFLOW(OVERFLOW), .OVERRUN(OVERRUN),
   .COUNTER_FOUR_GATE(COUNTER_FOUR_GATE), .DAC_UPDATE_N(DAC_UPDATE_N),
   .FIFO_REPLAY_PULSE_N(FIFO_REPLAY_PULSE_N), .REQUEST(REQUEST));
`default_nettype wire

// File: tb/wct_field_model.sv
// Connector-side timing signals: board clock, source pulses, trigger
`timescale 1ns/100ps
`default_nettype none
module wct_field_model #(
   parameter int HALF = 2
)
(
   input wire logic CLK,
   output logic board_clk,
   output logic [4:0] src,
   output logic trig_n
);
   int cnt = 0;
   initial
   begin
      board_clk = 1'b0;
      src = 5'h00;
      trig_n = 1'b1;
   end
   // Free-running board oscillator
   always @(posedge CLK)
   begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) board_clk <= ~board_clk;
   end
   task pulse(input int n);
      repeat (n)
      begin
         @(posedge CLK) src[0] <= 1'b1;
         repeat (3) @(posedge CLK);
         src[0] <= 1'b0;
         repeat (3) @(posedge CLK);
      end
   endtask : pulse
   task trig_fall();
      @(posedge CLK) trig_n <= 1'b0;
      repeat (4) @(posedge CLK);
      trig_n <= 1'b1;
   endtask : trig_fall
endmodule : wct_field_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the timing block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam int NR = 10;
   localparam int BP = 4;
   logic CLK = 1'b0;
   logic NRST = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic OVERFLOW = 1'b0;
   logic OVERRUN = 1'b0;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, cclk, divided_frequency_pin, counter_four_gate, upd_n, rep_n, req;
   logic [4:0] cout;
   logic [4:0] coe_n;
   wire logic bclk;
   wire logic trig_n;
   wire logic [4:0] src;
   int n_fail = 0;
   int tests_run = 0;
   int n_upd = 0;
   int n_rep = 0;
   int p;
   logic [31:0] q;
   logic e;
   logic [9:0] rw = 10'h02A;
   logic [9:0] re = 10'h160;
   logic [7:0] ra [NR] = '{8'h00, 8'h0C, 8'h0C, 8'h10, 8'h10, 8'h14, 8'h14, 8'h08, 8'h02, 8'h20};
   logic [31:0] dv [NR] = '{32'h0, 32'hABC, 32'hABC, 32'h1EF, 32'h1EF, 32'h5A5, 32'h0,
      32'h0, 32'h0, 32'h0};
   wct_timing dut (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .BOARD_TIMEBASE_CLOCK(bclk), .SOURCE_IN(src), .GATE_PINS(4'h0),
      .EXTERNAL_TRIGGER_PIN_N(trig_n), .EXT_UPDATE_TRIG_N(1'b1), .OVERFLOW(OVERFLOW),
      .OVERRUN(OVERRUN), .COUNTER_OUT(cout), .COUNTER_OUT_OE_N(coe_n), .COUNTER_CLOCK(cclk),
      .DIVIDED_FREQUENCY_PIN(divided_frequency_pin), .COUNTER_FOUR_GATE(counter_four_gate), .DAC_UPDATE_N(upd_n),
      .FIFO_REPLAY_PULSE_N(rep_n), .REQUEST(req));
   wct_field_model #(.HALF(BP / 2)) fm (.CLK(CLK), .board_clk(bclk), .src(src),
      .trig_n(trig_n));
   always #5 CLK = ~CLK;
   always @(posedge CLK)
   begin
      if (NRST && upd_n === 1'b0) n_upd++;
      if (NRST && rep_n === 1'b0) n_rep++;
   end
   task chk(input logic [31:0] x, input logic [31:0] g, input string nm);
      tests_run++;
      if (g !== x)
      begin
         $display("ERROR %s expected %h seen %h", nm, x, g);
         n_fail++;
      end
   endtask : chk
   // APB transfer, then a short settle
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do
      begin
         @(posedge CLK);
         n++;
      end
      while (PREADY !== 1'b1 && n < 20);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (n == 20) chk(1, 0, "pready");
      repeat (3) @(posedge CLK);
   endtask : apb
   // Clock cycles between two rising edges
   task meas(input logic s, output int per);
      int r;
      logic v, o;
      r = 0;
      per = 0;
      o = 1'b1;
      repeat (2000)
      begin
         @(posedge CLK);
         v = s ? divided_frequency_pin : cclk;
         if (r == 1) per++;
         if (v === 1'b1 && o === 1'b0) r++;
         o = v;
         if (r == 2) break;
      end
   endtask : meas
   task wrap_up();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      #300000;
      n_fail++;
      wrap_up();
   end
   initial
   begin
      repeat (19) @(posedge CLK);
      chk(10'h300, {upd_n, rep_n, req, counter_four_gate, PREADY, coe_n}, "reset");
      @(posedge CLK) NRST <= 1'b1;
      for (int i = 0; i < NR; i++)
      begin
         apb(rw[i], ra[i], dv[i]);
         chk(rw[i] ? 32'h0 : dv[i], q, "rdata");
         chk(re[i], e, "pslverr");
      end
      // ========
      // Counters
      apb(1'b1, 8'h20, 32'hB);
      apb(1'b1, 8'h40, 32'h3);
      fm.pulse(2);
      apb(1'b0, 8'h60, 32'h0);
      chk(1, q[15:0], "count");
      fm.pulse(1);
      chk(1, cout[0], "tc pulse");
      apb(1'b1, 8'h20, 32'h40B);
      chk(0, cout[0], "inverted");
      fm.pulse(1);
      chk(1, cout[0], "inverted idle");
      apb(1'b1, 8'h28, 32'h800);
      chk(1, coe_n[2], "hi-z");
      apb(1'b1, 8'h28, 32'h1000);
      chk(0, {coe_n[2], cout[2]}, "forced low");
      // ========
      // Cyclic playback
      apb(1'b1, 8'h0C, 32'h3);
      apb(1'b1, 8'h00, 32'h34F);
      n_upd = 0;
      n_rep = 0;
      repeat (4) apb(1'b1, 8'h08, 32'h4);
      chk(3, n_upd, "updates");
      chk(1, n_rep, "replays");
      chk(1, req, "request");
      apb(1'b1, 8'h08, 32'h10);
      chk(0, req, "request clear");
      apb(1'b0, 8'h04, 32'h0);
      chk(8, q[6:3], "state");
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h00, 32'h347);
      n_upd = 0;
      n_rep = 0;
      repeat (7) apb(1'b1, 8'h08, 32'h4);
      chk(7, n_upd, "updates");
      chk(2, n_rep, "replays");
      apb(1'b1, 8'h00, 32'h345);
      n_upd = 0;
      apb(1'b1, 8'h08, 32'h4);
      chk(0, n_upd, "halted");
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h20, 32'hC);
      apb(1'b1, 8'h0C, 32'h1);
      apb(1'b1, 8'h40, 32'h2);
      apb(1'b1, 8'h00, 32'h357);
      n_upd = 0;
      repeat (3) apb(1'b1, 8'h08, 32'h4);
      chk(2, n_upd, "counted");
      apb(1'b0, 8'h04, 32'h0);
      chk(5'h11, {q[6:3], q[0]}, "done");
      // ========
      // Timebases
      apb(1'b1, 8'h10, 32'h20);
      meas(1'b1, p);
      chk(2 * BP, p, "divided_frequency_pin tb0");
      apb(1'b1, 8'h10, 32'h81);
      meas(1'b1, p);
      chk(40 * BP, p, "divided_frequency_pin div");
      meas(1'b0, p);
      chk(10 * BP, p, "counter clock");
      // ========
      // Gate flop
      apb(1'b1, 8'h2C, 32'hE);
      fm.trig_fall();
      chk(1, counter_four_gate, "trig set");
      apb(1'b1, 8'h08, 32'h2);
      chk(0, counter_four_gate, "strobe clear");
      apb(1'b1, 8'h08, 32'h1);
      chk(1, counter_four_gate, "start set");
      OVERFLOW <= 1'b1;
      @(posedge CLK) OVERFLOW <= 1'b0;
      repeat (2) @(posedge CLK);
      chk(0, counter_four_gate, "overflow");
      OVERRUN <= 1'b1;
      apb(1'b1, 8'h08, 32'h1);
      chk(0, counter_four_gate, "clear wins");
      OVERRUN <= 1'b0;
      // Counter 5 cascaded on counter 4 ends the gate after four source pulses
      apb(1'b1, 8'h2C, 32'hB);
      apb(1'b1, 8'h4C, 32'h2);
      apb(1'b1, 8'h30, 32'h2000);
      apb(1'b1, 8'h50, 32'h2);
      apb(1'b1, 8'h08, 32'h1);
      fm.pulse(2);
      chk(1, counter_four_gate, "cascade low half");
      fm.pulse(2);
      chk(0, counter_four_gate, "cascade end");
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
